// *** zero_cross_detector.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "detector_params.svh"

module zero_cross_detector #(
   parameter int SYNC_STAGES = `SYNC_STAGES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic comparator_raw,
   input wire detector_pkg::sleep_mode_t sleep_mode,
   input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic detector_power,
   output logic event_out,
   output logic pin_out,
   output logic pin_out_en,
   output logic irq
);
   import detector_pkg::*;
   localparam logic [7:0] CTRL_INIT = `FIRST_CTRL_RESET;
   localparam logic [7:0] INT_INIT = `INT_CTRL_RESET;
   localparam logic [7:0] STAT_INIT = `STATUS_RESET;

   ctrl_t ctrl_q, ctrl_d;
   edge_mode_t edge_q, edge_d;
   logic flag_q, flag_d;
   logic prev_q, prev_d;
   logic irq_q, irq_d;
   logic event_q, event_d;
   logic pin_q, pin_d;
   logic pin_en_q, pin_en_d;
   logic power_q, power_d;
   logic awready_q, awready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic sync_out;
   logic run_ok;
   logic state_w;
   logic rise;
   logic fall;
   logic hit;
   logic we;
   logic clear_w;
   logic [5:0] widx;
   logic [5:0] ridx;

   // No event input port exists; the detector consumes nothing from routing
   level_sync #(
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(comparator_raw),
      .dout(sync_out)
   );

   // Sleep gating of the whole detector
   always_comb begin
      unique case (sleep_mode)
         SLEEP_ACTIVE: run_ok = ctrl_q.enable;
         SLEEP_IDLE: run_ok = ctrl_q.enable;
         SLEEP_STANDBY: run_ok = ctrl_q.enable && ctrl_q.run_standby;
         SLEEP_POWER_DOWN: run_ok = 1'b0;
         default: run_ok = 1'b0;
      endcase
   end

   // Synchronised, polarity-adjusted output; reads 0 while off
   assign state_w = run_ok && (sync_out ^ ctrl_q.invert);

   // Edge finding on the adjusted output, one sample back
   assign rise = state_w && !prev_q;
   assign fall = !state_w && prev_q;

   always_comb begin
      case (edge_q)
         EDGE_NONE: hit = 1'b0;
         EDGE_RISE: hit = rise;
         EDGE_FALL: hit = fall;
         EDGE_BOTH: hit = rise || fall;
         default: hit = 1'b0;
      endcase
   end

   // Bus decode
   assign we = awready_q;
   assign widx = s_axi_awaddr[7:2];
   assign ridx = s_axi_araddr[7:2];
   assign clear_w = we && (widx == `STATUS_IDX) && s_axi_wstrb[0]
                    && s_axi_wdata[`BIT_CROSS_FLAG];

   // Configuration and flag
   always_comb begin
      ctrl_d = ctrl_q;
      edge_d = edge_q;
      if (we && s_axi_wstrb[0]) begin
         if (widx == `FIRST_CTRL_IDX) begin
            ctrl_d.enable = s_axi_wdata[`BIT_ENABLE];
            ctrl_d.invert = s_axi_wdata[`BIT_INVERT];
            ctrl_d.out_en = s_axi_wdata[`BIT_OUT_EN];
            ctrl_d.run_standby = s_axi_wdata[`BIT_RUN_STDBY];
         end else if (widx == `INT_CTRL_IDX) begin
            edge_d = edge_mode_t'(s_axi_wdata[`EDGE_SEL_MSB:`EDGE_SEL_LSB]);
         end
      end
      // A crossing in the clearing cycle still sets the flag
      if (hit) begin
         flag_d = 1'b1;
      end else if (clear_w) begin
         flag_d = 1'b0;
      end else begin
         flag_d = flag_q;
      end
      prev_d = state_w;
      irq_d = flag_d && (edge_d != EDGE_NONE);
      event_d = state_w;
      pin_d = state_w && ctrl_q.out_en;
      pin_en_d = run_ok && ctrl_q.out_en;
      power_d = run_ok;
   end

   // Bus handshakes
   always_comb begin
      awready_d = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (we) begin
         bvalid_d = 1'b1;
         bresp_d = (widx <= `STATUS_IDX) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      arready_d = s_axi_arvalid && !arready_q && !rvalid_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = `RESP_OKAY;
         rdata_d = 32'h0000_0000;
         case (ridx)
            `FIRST_CTRL_IDX: begin
               rdata_d[`BIT_ENABLE] = ctrl_q.enable;
               rdata_d[`BIT_INVERT] = ctrl_q.invert;
               rdata_d[`BIT_OUT_EN] = ctrl_q.out_en;
               rdata_d[`BIT_RUN_STDBY] = ctrl_q.run_standby;
            end
            `RESERVED_IDX: rdata_d = 32'h0000_0000;
            `INT_CTRL_IDX: rdata_d[`EDGE_SEL_MSB:`EDGE_SEL_LSB] = edge_q;
            `STATUS_IDX: begin
               rdata_d[`BIT_STATE] = state_w;
               rdata_d[`BIT_CROSS_FLAG] = flag_q;
            end
            default: rresp_d = `RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= '{CTRL_INIT[`BIT_RUN_STDBY], CTRL_INIT[`BIT_OUT_EN],
                    CTRL_INIT[`BIT_INVERT], CTRL_INIT[`BIT_ENABLE]};
         edge_q <= edge_mode_t'(INT_INIT[`EDGE_SEL_MSB:`EDGE_SEL_LSB]);
         flag_q <= STAT_INIT[`BIT_CROSS_FLAG];
         prev_q <= 1'b0;
         irq_q <= 1'b0;
         event_q <= 1'b0;
         pin_q <= 1'b0;
         pin_en_q <= 1'b0;
         power_q <= 1'b0;
         awready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         edge_q <= edge_d;
         flag_q <= flag_d;
         prev_q <= prev_d;
         irq_q <= irq_d;
         event_q <= event_d;
         pin_q <= pin_d;
         pin_en_q <= pin_en_d;
         power_q <= power_d;
         awready_q <= awready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = awready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign detector_power = power_q;
   assign event_out = event_q;
   assign pin_out = pin_q;
   assign pin_out_en = pin_en_q;
   assign irq = irq_q;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_ENABLE_WRITE: assert property (
      we && s_axi_wstrb[0] && widx == `FIRST_CTRL_IDX && sleep_mode == SLEEP_ACTIVE
      ##1 sleep_mode == SLEEP_ACTIVE |=> detector_power == $past(s_axi_wdata[`BIT_ENABLE], 2))
      else $error("enable write not reflected in detector power");

   AST_STATE_LATENCY: assert property (
      (run_ok && $stable(ctrl_q.invert)) [*4]
      |-> state_w == ($past(comparator_raw, 3) ^ ctrl_q.invert))
      else $error("state bit does not follow input three cycles late");

   AST_EVENT_LEVEL: assert property (
      run_ok && !ctrl_q.invert |=> event_out == $past(sync_out))
      else $error("event output does not carry detector level");

   AST_FLAG_SET: assert property (
      hit |=> flag_q ##1 (flag_q || $past(clear_w)))
      else $error("crossing did not set flag");

   AST_FALL_IGNORED: assert property (
      edge_q == EDGE_RISE && fall && !flag_q && !clear_w |=> !flag_q)
      else $error("falling edge set flag in rising mode");

   AST_CLEAR_ONE: assert property (
      clear_w && !hit |=> !flag_q)
      else $error("writing one did not clear flag");

   AST_IRQ_LEVEL: assert property (
      flag_q && edge_q != EDGE_NONE |-> irq ##1 (irq || !flag_q || edge_q == EDGE_NONE))
      else $error("request not held while flag set");

   AST_NO_IRQ_NONE: assert property (
      edge_q == EDGE_NONE |-> !irq)
      else $error("request raised with interrupts off");

   AST_POWER_DOWN: assert property (
      sleep_mode == SLEEP_POWER_DOWN |=> !pin_out_en && !detector_power && !event_out)
      else $error("detector active in power-down");

   AST_STANDBY_OFF: assert property (
      sleep_mode == SLEEP_STANDBY && !ctrl_q.run_standby |=> !detector_power)
      else $error("detector active in standby without run bit");

   AST_IDLE_RUN: assert property (
      sleep_mode == SLEEP_IDLE && ctrl_q.enable |=> detector_power)
      else $error("detector stopped in idle");

   AST_PIN_GATE: assert property (
      !ctrl_q.out_en |=> !pin_out && !pin_out_en)
      else $error("pin driven without output enable");

   COV_FLAG_SET: cover property (hit ##1 irq);
   COV_SET_WINS: cover property (hit && clear_w);
   COV_PIN_DRIVE: cover property (pin_out_en && pin_out);
   COV_READ: cover property (arready_q ##1 rvalid_q && s_axi_rready);

endmodule : zero_cross_detector

`default_nettype wire

// *** detector_params.svh ***
`ifndef DETECTOR_PARAMS_SVH
`define DETECTOR_PARAMS_SVH

// Register indices; byte address is four times the index
`define FIRST_CTRL_IDX 6'h00
`define RESERVED_IDX 6'h01
`define INT_CTRL_IDX 6'h02
`define STATUS_IDX 6'h03

// First control register fields
`define BIT_ENABLE 0
`define BIT_INVERT 3
`define BIT_OUT_EN 6
`define BIT_RUN_STDBY 7

// Interrupt control and status fields
`define EDGE_SEL_LSB 0
`define EDGE_SEL_MSB 1
`define BIT_CROSS_FLAG 0
`define BIT_STATE 4

// Reset values
`define FIRST_CTRL_RESET 8'h00
`define INT_CTRL_RESET 8'h00
`define STATUS_RESET 8'h00

// Synchroniser depth in peripheral clock cycles
`define SYNC_STAGES 3

// Bus constants
`define AXI_ADDR_W 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** detector_pkg.sv ***
package detector_pkg;

   typedef enum logic [1:0] {
      SLEEP_ACTIVE,
      SLEEP_IDLE,
      SLEEP_STANDBY,
      SLEEP_POWER_DOWN
   } sleep_mode_t;

   typedef enum logic [1:0] {
      EDGE_NONE,
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } edge_mode_t;

   typedef struct packed {
      logic run_standby;
      logic out_en;
      logic invert;
      logic enable;
   } ctrl_t;

endpackage : detector_pkg

// *** level_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
   parameter int STAGES = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic din,
   output logic dout
);

   logic [STAGES-1:0] stage_q;
   logic [STAGES-1:0] stage_d;

   // Each stage reads only its predecessor
   generate
      for (genvar i = 0; i < STAGES; i++) begin : g_stage
         if (i == 0) begin : g_first
            always_comb begin
               stage_d[i] = din;
            end
         end else begin : g_next
            always_comb begin
               stage_d[i] = stage_q[i-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_q <= '0;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign dout = stage_q[STAGES-1];

endmodule : level_sync

`default_nettype wire

// *** comparator_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module comparator_model #(
   parameter int STARTUP_CYCLES = 4
) (
   input wire logic aclk,
   input wire logic detector_power,
   input wire logic above,
   output logic comparator_raw
);
   int cnt = 0;
   logic junk = 1'b0;

   // Output toggles while off or starting up, so a stale level never looks valid
   always @(posedge aclk) begin
      junk <= ~junk;
      if (!detector_power) begin
         cnt <= STARTUP_CYCLES;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end

   // Input pin is purely analog: no pull, no digital buffer in the path
   assign comparator_raw = (detector_power && cnt == 0) ? above : junk;
endmodule : comparator_model

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "detector_params.svh"

module tb_top;
   import detector_pkg::*;
   localparam logic [7:0] A_CTL = {`FIRST_CTRL_IDX, 2'b00};
   localparam logic [7:0] A_RSV = {`RESERVED_IDX, 2'b00};
   localparam logic [7:0] A_INT = {`INT_CTRL_IDX, 2'b00};
   localparam logic [7:0] A_STA = {`STATUS_IDX, 2'b00};
   localparam logic [1:0] OK = `RESP_OKAY;
   logic aclk, aresetn, above, raw, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, power, event_out, pin_out, pin_out_en, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, em;
   sleep_mode_t sleep;
   int n_errors, n_tests;

   zero_cross_detector u_zero_cross_detector (.aclk(aclk), .aresetn(aresetn),
      .comparator_raw(raw), .sleep_mode(sleep), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .detector_power(power), .event_out(event_out),
      .pin_out(pin_out), .pin_out_en(pin_out_en), .irq(irq));

   comparator_model u_comparator_model (.aclk(aclk), .detector_power(power),
      .above(above), .comparator_raw(raw));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic complete_run();
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic hang(input int n);
      if (n >= 50) begin
         n_errors++;
         complete_run();
      end
   endtask : hang

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ad, wd;
      n = 0;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd) && n < 50) begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1 && n < 50) begin
         @(posedge aclk);
         n++;
      end
      hang(n);
      bready <= 1'b0;
      chk(bresp, er);
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (arready !== 1'b1 && n < 50) begin
         @(posedge aclk);
         n++;
      end
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 50) begin
         @(posedge aclk);
         n++;
      end
      hang(n);
      rready <= 1'b0;
      chk(rdata, ed);
      chk(rresp, er);
      @(posedge aclk);
   endtask : rd

   initial begin
      {aresetn, above, awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      sleep = SLEEP_ACTIVE;
      n_errors = 0;
      n_tests = 0;
      tick(16);
      aresetn <= 1'b1;
      tick(1);
      rd(A_RSV, 32'h0, OK);
      rd(8'h10, 32'h0, `RESP_SLVERR);
      wr(8'h40, 32'hFF, `RESP_SLVERR);
      rd(A_CTL, 32'h0, OK);
      chk(power, 1'b0);
      wr(A_CTL, 32'h01, OK);
      tick(10);
      chk(power, 1'b1);
      rd(A_STA, 32'h0, OK);
      above <= 1'b1;
      tick(2);
      chk(event_out, 1'b0);
      tick(6);
      chk(event_out, 1'b1);
      rd(A_STA, 32'h10, OK);
      chk(pin_out_en, 1'b0);
      wr(A_CTL, 32'h49, OK);
      tick(8);
      rd(A_STA, 32'h0, OK);
      chk(pin_out_en, 1'b1);
      chk(pin_out, 1'b0);
      above <= 1'b0;
      tick(8);
      chk(pin_out, 1'b1);
      for (int m = 0; m < 4; m++) begin
         em = m[1:0];
         wr(A_CTL, 32'h01, OK);
         wr(A_INT, {30'h0, em}, OK);
         tick(8);
         wr(A_STA, 32'h1, OK);
         above <= 1'b1;
         tick(8);
         rd(A_STA, {28'h1, 3'b000, em[0]}, OK);
         chk(irq, em[0]);
         wr(A_STA, 32'h0, OK);
         rd(A_STA, {28'h1, 3'b000, em[0]}, OK);
         wr(A_STA, 32'h1, OK);
         above <= 1'b0;
         tick(8);
         rd(A_STA, {31'h0, em[1]}, OK);
         chk(irq, em[1]);
         wr(A_STA, 32'h1, OK);
         tick(2);
         chk(irq, 1'b0);
      end
      wr(A_INT, 32'h1, OK);
      wr(A_CTL, 32'h09, OK);
      tick(8);
      wr(A_STA, 32'h1, OK);
      above <= 1'b1;
      tick(8);
      rd(A_STA, 32'h0, OK);
      above <= 1'b0;
      tick(8);
      rd(A_STA, 32'h11, OK);
      wr(A_INT, 32'h0, OK);
      tick(2);
      chk(irq, 1'b0);
      rd(A_STA, 32'h11, OK);
      sleep <= SLEEP_IDLE;
      tick(4);
      chk(power, 1'b1);
      sleep <= SLEEP_STANDBY;
      tick(4);
      chk(power, 1'b0);
      chk(event_out, 1'b0);
      wr(A_CTL, 32'hC1, OK);
      rd(A_CTL, 32'hC1, OK);
      tick(4);
      chk(power, 1'b1);
      chk(pin_out_en, 1'b1);
      sleep <= SLEEP_POWER_DOWN;
      tick(4);
      chk(power, 1'b0);
      chk(pin_out_en, 1'b0);
      complete_run();
   end
endmodule : tb_top

`default_nettype wire
